// ==== core/cal_pkg.sv ====
// What this block does
// - voltage gain is coefficient over 16384, 0..32767
// - current gain is coefficient over 16384, 0..32767
// - zero delay coefficient means no phase compensation
// - run-time calibration is overwritten from flash copy
// - after reset load EEPROM copy, else flash
// - EEPROM lead byte 0xFF means no copy
// - stop compute engine by writing 0x00 first
// - unlock key then reset before erase allowed
// - programmer erases flash before loading code
// - after reset, freshly loaded code runs
// - program clock and data only active while enable high
// - port reset line is two-way, active low
// - downloader drives reset only while enabling port
package cal_pkg;
  localparam int unsigned CAL_WORDS = 9;
  localparam int unsigned GAIN_SHIFT = 14;
  // word indices; byte address is four times the index
  localparam logic [13:0] IDX_PHASE_A_CURRENT_GAIN = 14'h0010;
  localparam logic [13:0] IDX_PHASE_A_VOLTAGE_GAIN = 14'h0011;
  localparam logic [13:0] IDX_PHASE_A_DELAY_ADJUST = 14'h0012;
  localparam logic [13:0] IDX_PHASE_B_CURRENT_GAIN = 14'h0013;
  localparam logic [13:0] IDX_PHASE_B_VOLTAGE_GAIN = 14'h0014;
  localparam logic [13:0] IDX_PHASE_B_DELAY_ADJUST = 14'h0015;
  localparam logic [13:0] IDX_PHASE_C_CURRENT_GAIN = 14'h0016;
  localparam logic [13:0] IDX_PHASE_C_VOLTAGE_GAIN = 14'h0017;
  localparam logic [13:0] IDX_PHASE_C_DELAY_ADJUST = 14'h0018;
  localparam logic [13:0] IDX_DEVICE_STATUS = 14'h0020;
  localparam logic [13:0] IDX_CE_CONTROL = 14'h2000;
  localparam logic [13:0] IDX_FLASH_ERASE_UNLOCK = 14'h2702;
  localparam logic [15:0] GAIN_UNITY = 16'h4000;
  localparam logic [15:0] GAIN_MAX = 16'h7FFF;
  localparam logic [15:0] DELAY_DEFAULT = 16'h0000;
  localparam logic [15:0] FLASH_ERASED = 16'hFFFF;
  localparam logic [7:0] CE_CONTROL_RESET = 8'h01;
  localparam logic [7:0] CE_STOP_VALUE = 8'h00;
  localparam logic [7:0] UNLOCK_KEY = 8'h20;
  localparam logic [7:0] UNLOCK_RESET = 8'h00;
  localparam logic [7:0] EEPROM_BLANK = 8'hFF;
  // host registers
  localparam logic [13:0] HOST_IDX_COMMAND = 14'h0000;
  localparam logic [13:0] HOST_IDX_CONTROL = 14'h0001;
  localparam logic [13:0] HOST_IDX_STATUS = 14'h0002;
  // link frame: op[23:20] index[19:16] data[15:0]
  localparam int unsigned FRAME_BITS = 24;
  localparam logic [3:0] OP_ERASE = 4'h1;
  localparam logic [3:0] OP_WRITE = 4'h2;
  localparam logic [3:0] OP_COMMIT = 4'h3;
  localparam int unsigned LINK_HALF_CYCLES = 16;
  localparam int unsigned PORT_RESET_CYCLES = 8;
  typedef enum logic [1:0] {
    DL_IDLE = 2'b00, DL_SHIFT = 2'b01, DL_ACK = 2'b11
  } dev_link_state_t;
  typedef enum logic [1:0] {
    HL_IDLE = 2'b00, HL_SEND = 2'b01, HL_ACK = 2'b11
  } host_link_state_t;
endpackage

// ==== core/prog_port_if.sv ====
`timescale 1ns/100ps
interface prog_port_if;
  logic enable;
  logic clock;
  logic data_host_o;
  logic data_host_oe;
  logic data_dev_o;
  logic data_dev_oe;
  logic reset_host_n_o;
  logic reset_host_oe;
  logic reset_dev_n_o;
  logic reset_dev_oe;
  logic data_line;
  logic reset_n_line;
  // undriven data idles high as if pulled up
  assign data_line = data_host_oe ? data_host_o : (data_dev_oe ? data_dev_o : 1'b1);
  // open drain, either end may pull low
  assign reset_n_line = ~((reset_host_oe & ~reset_host_n_o) | (reset_dev_oe & ~reset_dev_n_o));
  modport device(input enable, input data_line, input reset_n_line, output clock,
                 output data_dev_o, output data_dev_oe, output reset_dev_n_o,
                 output reset_dev_oe);
  modport host(output enable, input data_line, input reset_n_line, input clock,
               output data_host_o, output data_host_oe, output reset_host_n_o,
               output reset_host_oe);
endinterface

// ==== core/pin_sync.sv ====
`timescale 1ns/100ps
module pin_sync #(
  parameter logic IDLE = 1'b0
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic pin,
  output logic level
);
  logic [2:0] ff;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ff <= {3{IDLE}};
    end else begin
      ff <= {ff[1:0], pin};
    end
  end
  // a change counts only once the second and third stage agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      level <= IDLE;
    end else if (ff[1] == ff[2]) begin
      level <= ff[2];
    end
  end
endmodule

// ==== core/cal_device.sv ====
`timescale 1ns/100ps
module cal_device #(
  parameter int unsigned LINK_HALF = cal_pkg::LINK_HALF_CYCLES
) (
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external eeprom image, word i at bits 16*i
  input wire logic [7:0] eeprom_lead,
  input wire logic [143:0] eeprom_cal,
  // measurement path, phase p at bits 16*p
  input wire logic [47:0] volt_sample,
  input wire logic [47:0] cur_sample,
  output logic [47:0] volt_scaled,
  output logic [47:0] cur_scaled,
  output logic ce_running,
  output logic code_running,
  // programming port
  prog_port_if.device port
);
  logic en_s;
  logic data_s;
  logic prst_n_s;
  logic restart;
  logic restart_q;
  logic restart_edge;
  logic load_pend;
  logic from_eeprom;
  logic [15:0] cal [cal_pkg::CAL_WORDS];
  logic [15:0] flash [cal_pkg::CAL_WORDS];
  logic code_valid;
  logic flash_blank;
  logic erase_armed;
  logic [7:0] ce_ctrl;
  logic [7:0] unlock;
  logic [13:0] idx;
  logic cal_hit;
  logic [3:0] cal_sel;
  logic rd_hit;
  logic [31:0] rd_val;
  logic wr_en;
  logic [15:0] wr_cal;
  logic [15:0] div_cnt;
  logic lclk;
  logic at_edge;
  logic rise;
  logic fall;
  cal_pkg::dev_link_state_t state;
  logic [4:0] bit_cnt;
  logic [23:0] shreg;
  logic exec;
  logic [1:0] ack_ph;
  logic ack_val;
  logic [3:0] op;
  logic [3:0] widx;

  pin_sync #(.IDLE(1'b0)) u_en (.clk_sys(clk_sys), .reset(reset), .pin(port.enable),
    .level(en_s));
  pin_sync #(.IDLE(1'b1)) u_data (.clk_sys(clk_sys), .reset(reset), .pin(port.data_line),
    .level(data_s));
  pin_sync #(.IDLE(1'b1)) u_rst (.clk_sys(clk_sys), .reset(reset), .pin(port.reset_n_line),
    .level(prst_n_s));

  // a low port reset line restarts the chip, but unlike the reset button it leaves flash untouched
  assign restart = ~prst_n_s;
  assign restart_edge = restart & ~restart_q;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      restart_q <= 1'b0;
      load_pend <= 1'b1;
    end else begin
      restart_q <= restart;
      load_pend <= restart;
    end
  end

  // apb decode
  assign idx = paddr[15:2];
  assign cal_sel = idx[3:0];
  assign cal_hit = (idx[13:4] == 10'h001) && (cal_sel < 4'(cal_pkg::CAL_WORDS));
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    if (cal_hit) begin
      rd_val = {16'h0000, cal[cal_sel]};
    end else if (idx == cal_pkg::IDX_CE_CONTROL) begin
      rd_val = {24'h000000, ce_ctrl};
    end else if (idx == cal_pkg::IDX_FLASH_ERASE_UNLOCK) begin
      rd_val = {24'h000000, unlock};
    end else if (idx == cal_pkg::IDX_DEVICE_STATUS) begin
      rd_val = {27'h0000000, flash_blank, from_eeprom, erase_armed, code_valid, code_running};
    end else begin
      rd_hit = 1'b0;
    end
  end
  // write lands on the edge that samples pready high
  assign wr_en = psel & penable & pready & pwrite;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= ~rd_hit;
        prdata <= pwrite ? 32'h00000000 : rd_val;
      end
    end
  end
  // gains only accept 0..32767, larger writes saturate
  assign wr_cal = (cal_sel == 4'h2 || cal_sel == 4'h5 || cal_sel == 4'h8 ||
                   pwdata[15:0] <= cal_pkg::GAIN_MAX) ? pwdata[15:0] : cal_pkg::GAIN_MAX;

  // calibration ram: volatile, reloaded at every reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      from_eeprom <= 1'b0;
      for (int i = 0; i < cal_pkg::CAL_WORDS; i++) begin
        cal[i] <= 16'h0000;
      end
    end else if (load_pend) begin
      from_eeprom <= eeprom_lead != cal_pkg::EEPROM_BLANK;
      for (int i = 0; i < cal_pkg::CAL_WORDS; i++) begin
        cal[i] <= (eeprom_lead != cal_pkg::EEPROM_BLANK) ? eeprom_cal[16*i +: 16]
                                                         : flash[i];
      end
    end else if (wr_en && cal_hit) begin
      cal[cal_sel] <= wr_cal;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || restart) begin
      ce_ctrl <= cal_pkg::CE_CONTROL_RESET;
      unlock <= cal_pkg::UNLOCK_RESET;
    end else if (wr_en) begin
      if (idx == cal_pkg::IDX_CE_CONTROL) begin
        ce_ctrl <= pwdata[7:0];
      end
      if (idx == cal_pkg::IDX_FLASH_ERASE_UNLOCK) begin
        unlock <= pwdata[7:0];
      end
    end
  end

  // arming needs key and stopped engine, both in place when the reset hits
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      erase_armed <= 1'b0;
    end else if (restart_edge) begin
      erase_armed <= (unlock == cal_pkg::UNLOCK_KEY) && (ce_ctrl == cal_pkg::CE_STOP_VALUE);
    end else if (exec && op == cal_pkg::OP_ERASE) begin
      erase_armed <= 1'b0;
    end
  end

  // flash keeps its contents over a port reset, only power-up restores defaults
  assign op = shreg[23:20];
  assign widx = shreg[19:16];
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      code_valid <= 1'b1;
      flash_blank <= 1'b0;
      for (int i = 0; i < cal_pkg::CAL_WORDS; i++) begin
        flash[i] <= (i % 3 == 2) ? cal_pkg::DELAY_DEFAULT : cal_pkg::GAIN_UNITY;
      end
    end else if (exec) begin
      if (op == cal_pkg::OP_ERASE && erase_armed) begin
        code_valid <= 1'b0;
        flash_blank <= 1'b1;
        for (int i = 0; i < cal_pkg::CAL_WORDS; i++) begin
          flash[i] <= cal_pkg::FLASH_ERASED;
        end
      end else if (op == cal_pkg::OP_WRITE && flash_blank &&
                   widx < 4'(cal_pkg::CAL_WORDS)) begin
        flash[widx] <= shreg[15:0];
      end else if (op == cal_pkg::OP_COMMIT && flash_blank) begin
        code_valid <= 1'b1;
        flash_blank <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      code_running <= 1'b1;
      ce_running <= 1'b0;
    end else begin
      ce_running <= ce_ctrl[0];
      if (restart_edge) begin
        code_running <= code_valid;
      end
    end
  end

  // port clock from a divider, running only while the port is enabled
  assign at_edge = en_s && (div_cnt == 16'(LINK_HALF - 1));
  assign rise = at_edge & ~lclk;
  assign fall = at_edge & lclk;
  always_ff @(posedge clk_sys) begin
    if (reset || !en_s) begin
      div_cnt <= 16'h0000;
      lclk <= 1'b0;
    end else if (at_edge) begin
      div_cnt <= 16'h0000;
      lclk <= ~lclk;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end
  assign port.clock = lclk;

  // frame: start bit 0, 24 bits msb first, then one ack bit from the device
  always_ff @(posedge clk_sys) begin
    if (reset || !en_s) begin
      state <= cal_pkg::DL_IDLE;
      bit_cnt <= 5'h00;
      shreg <= 24'h000000;
      exec <= 1'b0;
      ack_ph <= 2'h0;
      port.data_dev_oe <= 1'b0;
      port.data_dev_o <= 1'b1;
    end else begin
      exec <= 1'b0;
      unique case (state)
        cal_pkg::DL_IDLE: begin
          if (rise && !data_s) begin
            state <= cal_pkg::DL_SHIFT;
            bit_cnt <= 5'h00;
          end
        end
        cal_pkg::DL_SHIFT: begin
          if (rise) begin
            shreg <= {shreg[22:0], data_s};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'(cal_pkg::FRAME_BITS - 1)) begin
              exec <= 1'b1;
              state <= cal_pkg::DL_ACK;
              ack_ph <= 2'h0;
            end
          end
        end
        cal_pkg::DL_ACK: begin
          // skip one fall so the host has released the line first
          if (fall) begin
            ack_ph <= ack_ph + 2'h1;
            if (ack_ph == 2'h1) begin
              port.data_dev_oe <= 1'b1;
              port.data_dev_o <= ack_val;
            end else if (ack_ph == 2'h2) begin
              port.data_dev_oe <= 1'b0;
              state <= cal_pkg::DL_IDLE;
            end
          end
        end
        default: begin
          state <= cal_pkg::DL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_val <= 1'b0;
    end else if (exec) begin
      ack_val <= (op == cal_pkg::OP_ERASE && erase_armed) ||
                 (op == cal_pkg::OP_WRITE && flash_blank && widx < 4'(cal_pkg::CAL_WORDS)) ||
                 (op == cal_pkg::OP_COMMIT && flash_blank);
    end
  end

  // device pulls the port reset low while it is itself in reset
  always_ff @(posedge clk_sys) begin
    port.reset_dev_n_o <= 1'b0;
    port.reset_dev_oe <= reset;
  end

  // gain is coefficient/16384; delay adds coefficient/16384 times the sample slope
  for (genvar p = 0; p < 3; p++) begin : g_phase
    logic signed [15:0] v_now;
    logic signed [15:0] i_now;
    logic signed [15:0] v_prev;
    logic signed [31:0] v_prod;
    logic signed [31:0] i_prod;
    logic signed [32:0] d_prod;
    logic [15:0] v_q;
    logic [15:0] i_q;
    assign v_now = volt_sample[16*p +: 16];
    assign i_now = cur_sample[16*p +: 16];
    assign v_prod = v_now * $signed({1'b0, cal[3*p+1][14:0]});
    assign i_prod = i_now * $signed({1'b0, cal[3*p][14:0]});
    assign d_prod = ($signed({v_now[15], v_now}) - $signed({v_prev[15], v_prev}))
                    * $signed(cal[3*p+2]);
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        v_prev <= 16'sh0000;
        v_q <= 16'h0000;
        i_q <= 16'h0000;
      end else begin
        v_prev <= v_now;
        v_q <= 16'(v_prod[29:14] + d_prod[29:14]);
        i_q <= i_prod[29:14];
      end
    end
    assign volt_scaled[16*p +: 16] = v_q;
    assign cur_scaled[16*p +: 16] = i_q;
  end
endmodule

// ==== core/cal_prog_host.sv ====
`timescale 1ns/100ps
module cal_prog_host (
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // programming port
  prog_port_if.host port
);
  logic clk_s;
  logic clk_q;
  logic data_s;
  logic prst_n_s;
  logic rise;
  logic fall;
  logic [13:0] idx;
  logic wr_en;
  logic rd_hit;
  logic [31:0] rd_val;
  logic [23:0] command;
  logic start_pend;
  logic busy;
  logic done;
  logic ack;
  logic [7:0] rst_cnt;
  cal_pkg::host_link_state_t state;
  logic [4:0] bit_cnt;
  logic [23:0] sh;
  logic ack_seen;

  pin_sync #(.IDLE(1'b0)) u_clk (.clk_sys(clk_sys), .reset(reset), .pin(port.clock),
    .level(clk_s));
  pin_sync #(.IDLE(1'b1)) u_data (.clk_sys(clk_sys), .reset(reset), .pin(port.data_line),
    .level(data_s));
  pin_sync #(.IDLE(1'b1)) u_rst (.clk_sys(clk_sys), .reset(reset), .pin(port.reset_n_line),
    .level(prst_n_s));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_q <= 1'b0;
    end else begin
      clk_q <= clk_s;
    end
  end
  assign rise = clk_s & ~clk_q;
  assign fall = ~clk_s & clk_q;

  assign idx = paddr[15:2];
  assign wr_en = psel & penable & pready & pwrite;
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h00000000;
    unique case (idx)
      cal_pkg::HOST_IDX_COMMAND: rd_val = {8'h00, command};
      cal_pkg::HOST_IDX_CONTROL: rd_val = {31'h00000000, port.enable};
      cal_pkg::HOST_IDX_STATUS: rd_val = {28'h0000000, prst_n_s, done, ack, busy};
      default: rd_hit = 1'b0;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        pslverr <= ~rd_hit;
        prdata <= pwrite ? 32'h00000000 : rd_val;
      end
    end
  end

  // writing the command register queues one frame
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      command <= 24'h000000;
      start_pend <= 1'b0;
    end else if (wr_en && idx == cal_pkg::HOST_IDX_COMMAND) begin
      command <= pwdata[23:0];
      start_pend <= 1'b1;
    end else if (state == cal_pkg::HL_IDLE && (fall || !port.enable)) begin
      start_pend <= 1'b0;
    end
  end

  // port reset pulse is only issued with the enable being set
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port.enable <= 1'b0;
      rst_cnt <= 8'h00;
    end else if (wr_en && idx == cal_pkg::HOST_IDX_CONTROL) begin
      port.enable <= pwdata[0];
      rst_cnt <= (pwdata[0] && pwdata[1]) ? 8'(cal_pkg::PORT_RESET_CYCLES) : 8'h00;
    end else if (rst_cnt != 8'h00) begin
      rst_cnt <= rst_cnt - 8'h01;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      port.reset_host_n_o <= 1'b1;
      port.reset_host_oe <= 1'b0;
    end else begin
      port.reset_host_n_o <= 1'b0;
      port.reset_host_oe <= (rst_cnt != 8'h00) && port.enable;
    end
  end

  // data changes on sensed falls, the device samples on its own rises
  always_ff @(posedge clk_sys) begin
    if (reset || !port.enable) begin
      state <= cal_pkg::HL_IDLE;
      bit_cnt <= 5'h00;
      sh <= 24'h000000;
      ack_seen <= 1'b0;
      port.data_host_o <= 1'b1;
      port.data_host_oe <= 1'b0;
    end else begin
      unique case (state)
        cal_pkg::HL_IDLE: begin
          if (start_pend && fall) begin
            port.data_host_oe <= 1'b1;
            port.data_host_o <= 1'b0;
            sh <= command;
            bit_cnt <= 5'h00;
            state <= cal_pkg::HL_SEND;
          end
        end
        cal_pkg::HL_SEND: begin
          if (fall) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == 5'(cal_pkg::FRAME_BITS)) begin
              port.data_host_oe <= 1'b0;
              ack_seen <= 1'b0;
              state <= cal_pkg::HL_ACK;
            end else begin
              port.data_host_o <= sh[23];
              sh <= {sh[22:0], 1'b0};
            end
          end
        end
        cal_pkg::HL_ACK: begin
          if (rise) begin
            ack_seen <= 1'b1;
            if (ack_seen) begin
              state <= cal_pkg::HL_IDLE;
            end
          end
        end
        default: begin
          state <= cal_pkg::HL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack <= 1'b0;
      done <= 1'b0;
    end else if (state == cal_pkg::HL_ACK && rise && ack_seen) begin
      ack <= data_s;
      done <= 1'b1;
    end else if (wr_en && idx == cal_pkg::HOST_IDX_COMMAND) begin
      done <= 1'b0;
    end
  end
  assign busy = start_pend || (state != cal_pkg::HL_IDLE);
endmodule

// ==== bench/cal_checker.sv ====
`timescale 1ns/100ps
module cal_checker #(
  parameter int unsigned LINK_HALF = 16
) (
  // system
  input wire logic clk_sys,
  input wire logic reset,
  // port
  input wire logic enable,
  input wire logic clock,
  input wire logic data_host_oe,
  input wire logic data_dev_oe,
  input wire logic reset_host_n_o,
  input wire logic reset_host_oe,
  input wire logic reset_dev_n_o,
  input wire logic reset_dev_oe
);
  int hi;
  int ack;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // phase counters; a phase cut short by disabling is excused below
  always_ff @(posedge clk_sys) begin
    hi <= (reset || !clock) ? 0 : hi + 1;
  end
  always_ff @(posedge clk_sys) begin
    ack <= (reset || !data_dev_oe) ? 0 : ack + 1;
  end
  chk_clock_idle: assert property (!enable [*6] |-> !clock)
    else $error("clock runs while disabled");
  chk_data_idle: assert property (!enable [*6] |-> !data_dev_oe && !data_host_oe)
    else $error("data driven while disabled");
  chk_clock_half: assert property ($fell(clock) && enable |-> hi == LINK_HALF)
    else $error("clock high phase wrong");
  chk_ack_period: assert property ($fell(data_dev_oe) && enable |-> ack == 2 * LINK_HALF)
    else $error("ack drive length wrong");
  chk_one_driver: assert property (!(data_host_oe && data_dev_oe))
    else $error("both ends drive data");
  chk_host_rst_gate: assert property (reset_host_oe |-> enable)
    else $error("reset pulled while disabled");
  chk_host_rst_len: assert property (
    $rose(reset_host_oe) |-> reset_host_oe [*8] ##1 !reset_host_oe)
    else $error("reset pulse length wrong");
  chk_rst_low_only: assert property (
    !(reset_host_oe && reset_host_n_o) && !(reset_dev_oe && reset_dev_n_o))
    else $error("reset line driven high");
  cover property ($rose(reset_host_oe));
  cover property ($fell(data_dev_oe) && enable);
  cover property ($rose(data_host_oe));
endmodule

// ==== bench/tb_metering_calibration_and_program_port.sv ====
`timescale 1ns/100ps
module tb_metering_calibration_and_program_port;
  // short link phase keeps frames quick; still above the safe minimum
  localparam int unsigned HALF = 12;
  logic clk_sys;
  logic reset;
  logic sel[2];
  logic en[2];
  logic wr[2];
  logic [15:0] adr[2];
  logic [31:0] wd[2];
  logic [31:0] rdat[2];
  logic rdy[2];
  logic err[2];
  logic [7:0] lead;
  logic [143:0] ecal;
  logic [47:0] vs, cs, vo, co, v1, v2, c1, nv, nc;
  logic [15:0] sa, sb;
  logic ce_run;
  logic code_run;
  int n_errors;
  int n_tests;
  int cyc;
  int c;
  int calm[9];
  int flm[9];
  prog_port_if u_if();
  cal_device #(.LINK_HALF(HALF)) i_cal_device (.clk_sys(clk_sys), .reset(reset),
    .psel(sel[0]), .penable(en[0]), .pwrite(wr[0]), .paddr(adr[0]), .pwdata(wd[0]),
    .prdata(rdat[0]), .pready(rdy[0]), .pslverr(err[0]), .eeprom_lead(lead),
    .eeprom_cal(ecal), .volt_sample(vs), .cur_sample(cs), .volt_scaled(vo),
    .cur_scaled(co), .ce_running(ce_run), .code_running(code_run), .port(u_if.device));
  cal_prog_host i_cal_prog_host (.clk_sys(clk_sys), .reset(reset), .psel(sel[1]),
    .penable(en[1]), .pwrite(wr[1]), .paddr(adr[1]), .pwdata(wd[1]), .prdata(rdat[1]),
    .pready(rdy[1]), .pslverr(err[1]), .port(u_if.host));
  cal_checker #(.LINK_HALF(HALF)) i_cal_checker (.clk_sys(clk_sys), .reset(reset),
    .enable(u_if.enable), .clock(u_if.clock), .data_host_oe(u_if.data_host_oe),
    .data_dev_oe(u_if.data_dev_oe), .reset_host_n_o(u_if.reset_host_n_o),
    .reset_host_oe(u_if.reset_host_oe), .reset_dev_n_o(u_if.reset_dev_n_o),
    .reset_dev_oe(u_if.reset_dev_oe));
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] mul(input longint a, input longint b);
    longint p;
    p = a * b;
    return p[29:14];
  endfunction
  function automatic logic [15:0] da(input logic [13:0] i);
    return {i, 2'b00};
  endfunction
  task automatic apb(input int s, input logic w, input logic [15:0] a,
                     input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk_sys);
    sel[s] <= 1'b1;
    en[s] <= 1'b0;
    wr[s] <= w;
    adr[s] <= a;
    wd[s] <= d;
    @(posedge clk_sys);
    en[s] <= 1'b1;
    // request held until the edge that samples pready high; values read here are pre-edge
    do begin
      @(posedge clk_sys);
    end while (rdy[s] !== 1'b1);
    r = rdat[s];
    e = err[s];
    sel[s] <= 1'b0;
    en[s] <= 1'b0;
  endtask
  task automatic put(input int s, input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(s, 1'b1, a, d, r, e);
  endtask
  task automatic get(input int s, input logic [15:0] a, input logic [31:0] x,
                     input logic xe = 1'b0);
    logic [31:0] r;
    logic e;
    apb(s, 1'b0, a, 32'h0, r, e);
    chk(r, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  task automatic cal_chk();
    for (int i = 0; i < 9; i++)
      get(0, da(cal_pkg::IDX_PHASE_A_CURRENT_GAIN + 14'(i)), calm[i]);
  endtask
  task automatic frame(input logic [3:0] op, input logic [3:0] ix, input logic [15:0] d,
                       input logic ack);
    logic [31:0] r;
    logic e;
    put(1, 16'h0000, {8'h00, op, ix, d});
    do begin
      apb(1, 1'b0, 16'h0008, 32'h0, r, e);
    end while (r[2] !== 1'b1);
    chk({31'h0, r[1]}, {31'h0, ack});
  endtask
  // port restart through the host; the model reloads from eeprom or flash
  task automatic restart();
    put(1, 16'h0004, 32'h3);
    repeat (40) @(posedge clk_sys);
    for (int i = 0; i < 9; i++)
      calm[i] = (lead != 8'hFF) ? int'(ecal[16*i +: 16]) : flm[i];
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial begin
    reset = 1'b1;
    sel = '{1'b0, 1'b0};
    en = '{1'b0, 1'b0};
    wr = '{1'b0, 1'b0};
    adr = '{16'h0, 16'h0};
    wd = '{32'h0, 32'h0};
    lead = 8'hFF;
    ecal = '0;
    vs = '0;
    cs = '0;
    void'($urandom(71));
    for (int i = 0; i < 9; i++)
      flm[i] = (i % 3 == 2) ? 0 : 32'h4000;
    calm = flm;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (10) @(posedge clk_sys);
    cal_chk();
    get(0, da(cal_pkg::IDX_CE_CONTROL), 32'h1);
    get(0, 16'h0100, 32'h0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      c = (i % 3 == 2) ? ((i == 2) ? 0 : $urandom & 32'h3FF) : $urandom & 32'h7FFF;
      put(0, da(cal_pkg::IDX_PHASE_A_CURRENT_GAIN + 14'(i)), c);
      calm[i] = c;
    end
    put(0, da(cal_pkg::IDX_PHASE_A_CURRENT_GAIN), 32'hFFFF);
    calm[0] = 32'h7FFF;
    cal_chk();
    // phase a has zero delay, b and c compensate
    for (int n = 0; n < 12; n++) begin
      nv = 48'({$urandom, $urandom});
      nc = 48'({$urandom, $urandom});
      @(posedge clk_sys);
      vs <= nv;
      cs <= nc;
      @(negedge clk_sys);
      for (int p = 0; p < 3 && n > 1; p++) begin
        sa = v1[16*p +: 16];
        sb = v2[16*p +: 16];
        chk(co[16*p +: 16], mul($signed(c1[16*p +: 16]), calm[3*p]));
        chk(vo[16*p +: 16], 16'(mul($signed(sa), calm[3*p+1])
          + mul($signed(sa) - $signed(sb), calm[3*p+2])));
      end
      v2 = v1;
      v1 = nv;
      c1 = nc;
    end
    put(1, 16'h0004, 32'h1);
    frame(cal_pkg::OP_ERASE, 4'h0, 16'h0, 1'b0);
    frame(cal_pkg::OP_WRITE, 4'h0, 16'h1234, 1'b0);
    put(0, da(cal_pkg::IDX_CE_CONTROL), 32'(cal_pkg::CE_STOP_VALUE));
    // engine flag follows the control write one clock later
    repeat (2) @(negedge clk_sys);
    chk({31'h0, ce_run}, 32'h0);
    put(0, da(cal_pkg::IDX_FLASH_ERASE_UNLOCK), 32'(cal_pkg::UNLOCK_KEY));
    restart();
    get(0, da(cal_pkg::IDX_DEVICE_STATUS), 32'h07);
    cal_chk();
    frame(cal_pkg::OP_ERASE, 4'h0, 16'h0, 1'b1);
    for (int i = 0; i < 9; i++) begin
      flm[i] = $urandom & 32'h7FFF;
      frame(cal_pkg::OP_WRITE, 4'(i), 16'(flm[i]), 1'b1);
    end
    frame(cal_pkg::OP_WRITE, 4'h9, 16'h0, 1'b0);
    frame(cal_pkg::OP_COMMIT, 4'h0, 16'h0, 1'b1);
    restart();
    get(0, da(cal_pkg::IDX_DEVICE_STATUS), 32'h03);
    chk({31'h0, code_run}, 32'h1);
    cal_chk();
    lead <= 8'($urandom % 255);
    for (int i = 0; i < 9; i++)
      ecal[16*i +: 16] <= 16'($urandom & 32'h7FFF);
    restart();
    get(0, da(cal_pkg::IDX_DEVICE_STATUS), 32'h0B);
    cal_chk();
    lead <= 8'hFF;
    restart();
    cal_chk();
    put(1, 16'h0004, 32'h0);
    repeat (20) @(posedge clk_sys);
    tally_and_finish();
  end
endmodule
